// [verilog/ivc_capture.sv]
/*
 * Interrupt vector capture for one terminal: builds the captured word,
 * queues it with a timestamp in a 16 word FIFO, raises the processor interrupt.
 * Assumes all inputs synchronous to sys_clk; the processor pops by ready/valid.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ivc_defines.svh"
// Behaviour
// - Per-terminal 36-bit queue: vector plus timestamp
// - Interrupt held while queue not empty
// - Transmit cells carry vector, early/late enables
// - Receive cells hold vector storage
// - Bits 4-12 copied from programmed vector
// - Bit 13 mirrors string error status
// - Bit 14 samples string active indicator
// - Bit 15 carries queue almost-full flag
// - Programmed bit 14 selects label extension
// - Substitution reliable only for late vectors
// - Label top four bits are channel identifier

// ****************************************
// Queue module
// ****************************************
module ivc_fifo #(
    parameter int WIDTH = `IVC_WORD_W,
    parameter int DEPTH = `IVC_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic almost_full,
    output logic empty
);
    // Storage array, not reset: contents only read once written
    logic [WIDTH-1:0] mem_r [DEPTH];
    ivc_pkg::ivc_fifo_state_type st_r;
    ivc_pkg::ivc_fifo_state_type st_nxt;
    logic push;
    logic pop_mem;
    logic take_out;

    // Output stage refill: empty stage or being drained this cycle
    assign take_out = !st_r.out_valid_r || out_ready;
    assign pop_mem = take_out && (st_r.count_r != `IVC_CNT_RST);
    // Full queue refuses, so no unread entry is overwritten
    assign in_ready = (st_r.count_r != 5'(DEPTH));
    assign push = in_valid && in_ready;
    assign out_valid = st_r.out_valid_r;
    assign out_data = st_r.out_data_r;
    assign almost_full = (st_r.count_r >= `IVC_AFULL_LVL);
    // Empty as of the coming edge: a registered irq then neither lags nor dips
    assign empty = (st_nxt.count_r == `IVC_CNT_RST) && !st_nxt.out_valid_r;

    // Next state of pointers, count and output stage
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wr_ptr_r = st_r.wr_ptr_r + 4'h1;
        end
        if (pop_mem) begin
            // One entry leaves whole, vector and time together
            st_nxt.rd_ptr_r = st_r.rd_ptr_r + 4'h1;
            st_nxt.out_data_r = mem_r[st_r.rd_ptr_r];
            st_nxt.out_valid_r = 1'b1;
        end else if (take_out) begin
            st_nxt.out_valid_r = 1'b0;
        end
        if (push && !pop_mem) begin
            st_nxt.count_r = st_r.count_r + 5'h01;
        end else if (!push && pop_mem) begin
            st_nxt.count_r = st_r.count_r - 5'h01;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Array write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[st_r.wr_ptr_r] <= in_data;
        end
    end

    // ****************************************
    // Checks of the queue
    // ****************************************
    property p_no_push_full;
        @(posedge sys_clk) disable iff (!rst_n)
        (st_r.count_r == 5'(DEPTH)) |-> !in_ready;
    endproperty
    a_no_push_full: assert property (p_no_push_full) else $error("push accepted when full");

    property p_count_up;
        @(posedge sys_clk) disable iff (!rst_n)
        (push && !pop_mem) |=> (st_r.count_r == $past(st_r.count_r) + 5'h01);
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not rise on push");

    property p_count_down;
        @(posedge sys_clk) disable iff (!rst_n)
        (!push && pop_mem) |=> (st_r.count_r == $past(st_r.count_r) - 5'h01);
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not fall on pop");

    property p_pop_data;
        @(posedge sys_clk) disable iff (!rst_n)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_data));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("stalled output changed");

    property p_afull;
        @(posedge sys_clk) disable iff (!rst_n)
        almost_full |-> (st_r.count_r >= 5'h0c);
    endproperty
    a_afull: assert property (p_afull) else $error("almost full without level");

    property p_afull_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        ((st_r.count_r == 5'h0b) && push && !pop_mem) |=> almost_full;
    endproperty
    a_afull_rise: assert property (p_afull_rise) else $error("almost full did not rise");

    c_full: cover property (@(posedge sys_clk) disable iff (!rst_n) !in_ready);
    c_drain: cover property (@(posedge sys_clk) disable iff (!rst_n) out_valid && out_ready);
endmodule

// ****************************************
// Capture top
// ****************************************
module ivc_capture (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic vec_strobe,
    input wire logic [`IVC_VEC_W-1:0] vec_prog,
    input wire logic string_error,
    input wire logic string_active_indicator,
    input wire logic label_strobe,
    input wire logic [15:0] label_value,
    input wire logic [`IVC_TS_W-1:0] timestamp,
    output logic proc_irq,
    output logic proc_valid,
    input wire logic proc_ready,
    output logic [`IVC_WORD_W-1:0] proc_data,
    output logic vec_dropped
);
    ivc_pkg::ivc_top_state_type st_r;
    ivc_pkg::ivc_top_state_type st_nxt;
    logic fifo_ready;
    logic fifo_afull;
    logic fifo_empty;
    logic [`IVC_VEC_W-1:0] vec_word;
    logic vec_take; // Strobe accepted into the input stage

    // Captured word assembly from table vector and live status
    always_comb begin
        vec_word = '0;
        vec_word[`IVC_MID_HI:`IVC_MID_LO] = vec_prog[`IVC_MID_HI:`IVC_MID_LO];
        vec_word[`IVC_ERR_BIT] = string_error;
        vec_word[`IVC_ACT_BIT] = string_active_indicator;
        vec_word[`IVC_AF_BIT] = fifo_afull;
        // Extension is only current after the label arrives: late vectors only
        if (vec_prog[`IVC_SUBST_BIT]) begin
            vec_word[`IVC_LOW_HI:0] = st_r.channel_identifier_r;
        end else begin
            vec_word[`IVC_LOW_HI:0] = vec_prog[`IVC_LOW_HI:0];
        end
    end

    // Next state of top registers
    always_comb begin
        st_nxt = st_r;
        if (label_strobe) begin
            st_nxt.channel_identifier_r = label_value[`IVC_CHAN_HI:`IVC_CHAN_LO];
        end
        // One-stage input register; a stalled entry is held, a new one dropped
        if (st_r.in_valid_r && fifo_ready) begin
            st_nxt.in_valid_r = 1'b0;
        end
        st_nxt.dropped_r = 1'b0;
        if (vec_strobe) begin
            if (!st_r.in_valid_r || fifo_ready) begin
                st_nxt.in_valid_r = 1'b1;
                st_nxt.in_word_r = {vec_word, timestamp};
            end else begin
                st_nxt.dropped_r = 1'b1;
            end
        end
        st_nxt.irq_r = !fifo_empty || st_nxt.in_valid_r;
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Vector queue
    ivc_fifo #(.WIDTH(`IVC_WORD_W), .DEPTH(`IVC_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(st_r.in_valid_r),
        .in_ready(fifo_ready),
        .in_data(st_r.in_word_r),
        .out_valid(proc_valid),
        .out_ready(proc_ready),
        .out_data(proc_data),
        .almost_full(fifo_afull),
        .empty(fifo_empty)
    );

    assign proc_irq = st_r.irq_r;
    assign vec_dropped = st_r.dropped_r;
    assign vec_take = vec_strobe && (!st_r.in_valid_r || fifo_ready);

    // ****************************************
    // Checks of the capture path
    // ****************************************
    property p_irq_held;
        @(posedge sys_clk) disable iff (!rst_n)
        proc_valid |-> proc_irq;
    endproperty
    a_irq_held: assert property (p_irq_held) else $error("irq low with data queued");

    property p_mid_bits;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_strobe && !st_r.in_valid_r) |=>
            (st_r.in_word_r[32:24] == $past(vec_prog[12:4]));
    endproperty
    a_mid_bits: assert property (p_mid_bits) else $error("vector bits 4-12 altered");

    property p_low_subst;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_strobe && !st_r.in_valid_r && vec_prog[14]) |=>
            (st_r.in_word_r[23:20] == $past(st_r.channel_identifier_r));
    endproperty
    a_low_subst: assert property (p_low_subst) else $error("extension not substituted");

    property p_status_bits;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_strobe && !st_r.in_valid_r) |=>
            (st_r.in_word_r[34:33] == $past({string_active_indicator, string_error}));
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status bits wrong");

    property p_drop;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_strobe && st_r.in_valid_r && !fifo_ready) |=> vec_dropped;
    endproperty
    a_drop: assert property (p_drop) else $error("drop not flagged");

    property p_irq_transit;
        @(posedge sys_clk) disable iff (!rst_n)
        (st_r.in_valid_r && fifo_ready) |=> proc_irq;
    endproperty
    a_irq_transit: assert property (p_irq_transit) else $error("irq dipped in transit");

    property p_irq_rise;
        @(posedge sys_clk) disable iff (!rst_n)
        vec_take |=> proc_irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq not raised by capture");

    property p_time_bits;
        @(posedge sys_clk) disable iff (!rst_n)
        vec_take |=> (st_r.in_word_r[19:0] == $past(timestamp));
    endproperty
    a_time_bits: assert property (p_time_bits) else $error("timestamp not captured");

    property p_keep_low;
        @(posedge sys_clk) disable iff (!rst_n)
        (vec_take && !vec_prog[14]) |=> (st_r.in_word_r[23:20] == $past(vec_prog[3:0]));
    endproperty
    a_keep_low: assert property (p_keep_low) else $error("low vector bits altered");

    property p_af_bit;
        @(posedge sys_clk) disable iff (!rst_n)
        vec_take |=> (st_r.in_word_r[35] == $past(fifo_afull));
    endproperty
    a_af_bit: assert property (p_af_bit) else $error("almost full bit wrong");

    c_capture: cover property (@(posedge sys_clk) disable iff (!rst_n) vec_strobe);
    c_subst: cover property (@(posedge sys_clk) disable iff (!rst_n) vec_strobe && vec_prog[14]);
endmodule
`default_nettype wire

// [verilog/ivc_defines.svh]
/*
 * Constants for the interrupt vector capture block: word layout and queue sizes.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef IVC_DEFINES_SVH
`define IVC_DEFINES_SVH
`define IVC_VEC_W 16
`define IVC_TS_W 20
`define IVC_WORD_W 36
`define IVC_DEPTH 16
`define IVC_PTR_W 4
`define IVC_CNT_W 5
`define IVC_AFULL_LVL 5'h0c
`define IVC_LOW_HI 3
`define IVC_MID_LO 4
`define IVC_MID_HI 12
`define IVC_ERR_BIT 13
`define IVC_ACT_BIT 14
`define IVC_AF_BIT 15
`define IVC_SUBST_BIT 14
`define IVC_CHAN_LO 12
`define IVC_CHAN_HI 15
`define IVC_CNT_RST 5'h00
`define IVC_PTR_RST 4'h0
`endif

// [verilog/ivc_pkg.sv]
/*
 * Types of the interrupt vector capture block.
 * Assumes ivc_defines.svh is on the include path.
 */
`include "ivc_defines.svh"
package ivc_pkg;
    // Register state of the queue
    typedef struct packed {
        logic [`IVC_PTR_W-1:0] wr_ptr_r;
        logic [`IVC_PTR_W-1:0] rd_ptr_r;
        logic [`IVC_CNT_W-1:0] count_r;
        logic out_valid_r;
        logic [`IVC_WORD_W-1:0] out_data_r;
    } ivc_fifo_state_type;
    // Register state of the capture top
    typedef struct packed {
        logic [3:0] channel_identifier_r;
        logic in_valid_r;
        logic [`IVC_WORD_W-1:0] in_word_r;
        logic dropped_r;
        logic irq_r;
    } ivc_top_state_type;
endpackage

// [tb/ivc_proc_model.sv]
/*
 * Processor side model: pops captured entries from the vector queue.
 * Assumes sys_clk, active low rst_n, and a mode chosen by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Draining processor
// ****************************************
module ivc_proc_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic proc_valid,
    input wire logic [1:0] mode,
    output logic proc_ready
);
    logic [1:0] phase_r; // Slow mode pacing
    // Ready: 0 prompt, 1 every third cycle, 2 stalled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= 2'h0;
            proc_ready <= 1'b0;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            // One whole entry per pop; ready is set by mode and phase only, proc_valid is not looked at
            proc_ready <= (mode == 2'h0) || (mode == 2'h1 && phase_r == 2'h0);
        end
    end
endmodule
`default_nettype wire

// [tb/interrupt_vector_capture_tb.sv]
/*
 * Self-checking bench of ivc_capture: terminal stimulus, expected words.
 * Assumes the design files and ivc_proc_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module interrupt_vector_capture_tb;
    logic sys_clk, rst_n, vec_strobe, string_error, string_active_indicator, label_strobe;
    logic [15:0] vec_prog, label_value;
    logic [19:0] timestamp;
    logic proc_irq, proc_valid, proc_ready, vec_dropped;
    logic [35:0] proc_data;
    logic [1:0] mode; // Drain speed of the processor model
    logic [3:0] ext; // Last label extension seen
    logic [35:0] exp_q[$]; // Expected entries in order
    logic [1:0] af_q[$]; // Almost-full bit: known flag, value
    logic [35:0] w, m;
    logic [1:0] k;
    logic [31:0] seed, r;
    int mismatches, total_checks, drops;
    ivc_capture dut (.sys_clk(sys_clk), .rst_n(rst_n), .vec_strobe(vec_strobe),
        .vec_prog(vec_prog), .string_error(string_error),
        .string_active_indicator(string_active_indicator), .label_strobe(label_strobe),
        .label_value(label_value), .timestamp(timestamp), .proc_irq(proc_irq),
        .proc_valid(proc_valid), .proc_ready(proc_ready), .proc_data(proc_data),
        .vec_dropped(vec_dropped));
    ivc_proc_model proc (.sys_clk(sys_clk), .rst_n(rst_n), .proc_valid(proc_valid),
        .mode(mode), .proc_ready(proc_ready));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Word: af, active, error, prog 12:4, low bits or extension, then time
    function automatic logic [35:0] expw(logic [15:0] p, logic e, logic a, logic f,
            logic [3:0] x, logic [19:0] t);
        return {f, a, e, p[12:4], p[14] ? x : p[3:0], t};
    endfunction
    // One cycle of terminal activity; push marks an entry that must survive
    task automatic drive(input logic vs, input logic [15:0] p, input logic e, input logic a,
            input logic ls, input logic [15:0] l, input logic push, input logic [1:0] af);
        @(posedge sys_clk);
        vec_strobe <= vs;
        vec_prog <= p;
        string_error <= e;
        string_active_indicator <= a;
        label_strobe <= ls;
        label_value <= l;
        if (vs && push) begin
            exp_q.push_back(expw(p, e, a, af[0], ext, timestamp + 20'h0_0001));
            af_q.push_back(af);
        end
        // Same-cycle label only reaches later vectors
        if (ls) ext = l[15:12];
    endtask
    // Wait for the queue to empty, then interrupt and valid must fall
    task automatic drain();
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK("irq_idle", 1'b0, proc_irq)
        `CHK("valid_idle", 1'b0, proc_valid)
        `CHK("left", 0, exp_q.size())
    endtask
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // Clock, time base and monitors
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) timestamp <= timestamp + 20'h0_0001;
    // Compare every popped entry; unknown almost-full bits are masked
    always @(posedge sys_clk) begin
        if (vec_dropped === 1'b1) drops++;
        if (rst_n && proc_valid === 1'b1 && proc_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                w = 36'h0_0000_0000;
                k = 2'b10;
            end else begin
                w = exp_q.pop_front();
                k = af_q.pop_front();
            end
            m = k[1] ? 36'hF_FFFF_FFFF : 36'h7_FFFF_FFFF;
            `CHK("entry", w & m, proc_data & m)
        end
    end
    initial begin
        // About 20000 cycles: several times the longest expected run
        #400000;
        mismatches++;
        conclude();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {rst_n, vec_strobe, string_error, string_active_indicator, label_strobe} = 5'h00;
        {vec_prog, label_value, timestamp, mode, ext} = 0;
        {mismatches, total_checks, drops} = 0;
        seed = 32'h0000_000F;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Single vector with label substitution, latency walk
        drive(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h5123, 1'b1, 2'b10);
        drive(1'b1, 16'h4ABC, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b1, 2'b10);
        drive(1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 2'b10);
        #1;
        `CHK("irq_up", 1'b1, proc_irq)
        @(posedge sys_clk);
        #1;
        `CHK("irq_transit", 1'b1, proc_irq)
        @(posedge sys_clk);
        #1;
        `CHK("valid_up", 1'b1, proc_valid)
        drain();
        // Random traffic, labels alone and with vectors
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            drive(r[0] | r[1], r[31:16], r[2], r[3], r[4] & r[5], r[23:8], 1'b1, 2'b10);
        end
        drive(1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 2'b10);
        drain();
        // Stalled processor, flood of 20: 18 held, 2 discarded
        mode <= 2'h2;
        drops = 0;
        for (int i = 0; i < 20; i++) begin
            r = rnd();
            drive(1'b1, r[31:16], r[2], r[3], r[4], r[23:8], i < 18,
                {i == 0 || i == 17, i == 17});
        end
        drive(1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 2'b10);
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK("drops", 2, drops)
        `CHK("irq_full", 1'b1, proc_irq)
        mode <= 2'h1;
        drain();
        conclude();
    end
endmodule
`default_nettype wire
